// ==== pkg/podp_defines.vh ====
// constants for the panel output driver protection block
// Notes on behaviour
// - two sizes: 96 inputs with 64 outputs, or 64 inputs with 32 outputs.
// - input bit reads 1 for a closed contact, 0 for an open one.
// - outputs form driver groups of eight sharing one overheat state.
// - overcurrent on one output switches only that output off.
// - output returns by itself once overcurrent clears; faults cycle on and off.
// - group overheat switches off and latches all eight outputs of the group.
// - controller commands off then on after overheat clears to restore an output.
// - power cycle (reset) clears the overheat latches.
// - group red indicator lights once that group's overheat has operated.
// - any group overheat raises a system alarm to the controller.
// - closed alarm-mask jumper suppresses the alarm, indicator still lights.
// - indicator n covers output byte n, bits n.0 to n.7.
// - indicators and alarm exist only on board revision 03B and later.
`ifndef PODP_DEFINES_VH
`define PODP_DEFINES_VH
`define PODP_GROUP_BITS   8
`define PODP_IN_LARGE     96
`define PODP_OUT_LARGE    64
`define PODP_IN_SMALL     64
`define PODP_OUT_SMALL    32
`endif

// ==== rtl/podp_panel_io.v ====
// operator panel digital i/o with per-group output driver protection
`timescale 1ns/100ps
`default_nettype none
`include "podp_defines.vh"
module podp_panel_io #(
  parameter LARGE_UNIT = 1,
  parameter N_IN       = LARGE_UNIT ? `PODP_IN_LARGE : `PODP_IN_SMALL,
  parameter N_OUT      = LARGE_UNIT ? `PODP_OUT_LARGE : `PODP_OUT_SMALL,
  parameter N_GRP      = N_OUT / `PODP_GROUP_BITS
) (
  // clock and reset
  input  wire              clock_in,
  input  wire              rst_in,
  // board options
  input  wire              rev_has_alarm_in,
  input  wire              alarm_mask_jumper_in,
  // contact inputs and controller output commands
  input  wire [N_IN-1:0]   contact_closed_in,
  output reg  [N_IN-1:0]   input_bits_out,
  input  wire [N_OUT-1:0]  output_cmd_in,
  // driver element sense
  input  wire [N_OUT-1:0]  overcurrent_detector_in,
  input  wire [N_GRP-1:0]  overheat_detector_in,
  // panel side drive and status
  output reg  [N_OUT-1:0]  output_drive_out,
  output reg  [N_GRP-1:0]  group_overheat_led_out,
  output reg               system_alarm_out
);
  // three-stage synchronisers for the contact, detector and mask-jumper inputs
  reg [N_IN-1:0]  ci_s1, ci_s2, ci_s3;
  reg [N_OUT-1:0] oc_s1, oc_s2, oc_s3, oc_q;
  reg [N_GRP-1:0] oh_s1, oh_s2, oh_s3, oh_q;
  reg             msk_s1, msk_s2, msk_s3, msk_q;
  reg [N_OUT-1:0] cmd_prev;
  reg [N_OUT-1:0] latch;
  reg [N_OUT-1:0] seen_off;
  reg [N_GRP-1:0] grp_tripped;
  wire [N_OUT-1:0] next_latch;
  wire [N_OUT-1:0] next_seen_off;
  wire [N_OUT-1:0] next_drive;
  integer i;

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ci_s1 <= {N_IN{1'b0}};
      ci_s2 <= {N_IN{1'b0}};
      ci_s3 <= {N_IN{1'b0}};
      oc_s1 <= {N_OUT{1'b0}};
      oc_s2 <= {N_OUT{1'b0}};
      oc_s3 <= {N_OUT{1'b0}};
      oc_q  <= {N_OUT{1'b0}};
      oh_s1 <= {N_GRP{1'b0}};
      oh_s2 <= {N_GRP{1'b0}};
      oh_s3 <= {N_GRP{1'b0}};
      oh_q  <= {N_GRP{1'b0}};
      msk_s1 <= 1'b0;
      msk_s2 <= 1'b0;
      msk_s3 <= 1'b0;
      msk_q  <= 1'b0;
      input_bits_out <= {N_IN{1'b0}};
    end else begin
      ci_s1 <= contact_closed_in;
      ci_s2 <= ci_s1;
      ci_s3 <= ci_s2;
      oc_s1 <= overcurrent_detector_in;
      oc_s2 <= oc_s1;
      oc_s3 <= oc_s2;
      oh_s1 <= overheat_detector_in;
      oh_s2 <= oh_s1;
      oh_s3 <= oh_s2;
      msk_s1 <= alarm_mask_jumper_in;
      msk_s2 <= msk_s1;
      msk_s3 <= msk_s2;
      // a change counts only once stages two and three agree
      for (i = 0; i < N_IN; i = i + 1) begin
        if (ci_s2[i] == ci_s3[i])
          input_bits_out[i] <= ci_s3[i];
      end
      for (i = 0; i < N_OUT; i = i + 1) begin
        if (oc_s2[i] == oc_s3[i])
          oc_q[i] <= oc_s3[i];
      end
      for (i = 0; i < N_GRP; i = i + 1) begin
        if (oh_s2[i] == oh_s3[i])
          oh_q[i] <= oh_s3[i];
      end
      if (msk_s2 == msk_s3)
        msk_q <= msk_s3;
    end
  end

  // group index of an output bit, shared by every per-bit slice
  function integer podp_grp_of;
    input integer bit_idx;
    begin
      podp_grp_of = bit_idx / `PODP_GROUP_BITS;
    end
  endfunction

  // one slice per output; no loop variable shared with the clocked process
  genvar g;
  generate
    for (g = 0; g < N_OUT; g = g + 1) begin : gen_out
      wire grp_hot;
      wire fresh_on;
      assign grp_hot  = oh_q[podp_grp_of(g)];
      assign fresh_on = output_cmd_in[g] & ~cmd_prev[g] & seen_off[g];
      // group overheat latches all eight; set wins over clear
      assign next_latch[g]    = grp_hot | (latch[g] & ~fresh_on);
      assign next_seen_off[g] = ~grp_hot & (~output_cmd_in[g] | (seen_off[g] & ~fresh_on));
      // follows detector, so it retries itself
      assign next_drive[g] = output_cmd_in[g] & ~next_latch[g] & ~oc_q[g];
    end
  endgenerate

  always @(posedge clock_in or posedge rst_in) begin
    // reset acts as the power cycle
    if (rst_in) begin
      latch                  <= {N_OUT{1'b0}};
      seen_off               <= {N_OUT{1'b0}};
      cmd_prev               <= {N_OUT{1'b0}};
      grp_tripped            <= {N_GRP{1'b0}};
      output_drive_out       <= {N_OUT{1'b0}};
      group_overheat_led_out <= {N_GRP{1'b0}};
      system_alarm_out       <= 1'b0;
    end else begin
      latch            <= next_latch;
      seen_off         <= next_seen_off;
      cmd_prev         <= output_cmd_in;
      output_drive_out <= next_drive;
      grp_tripped      <= grp_tripped | oh_q;
      // indicator per output byte, held until reset
      group_overheat_led_out <= rev_has_alarm_in ? (grp_tripped | oh_q) : {N_GRP{1'b0}};
      system_alarm_out <= rev_has_alarm_in & ~msk_q & (|(grp_tripped | oh_q));
    end
  end
endmodule // podp_panel_io
`default_nettype wire

// ==== test/podp_panel_load.sv ====
// shorted panel loads at the driver outputs
`timescale 1ns/100ps
`default_nettype none
module podp_panel_load (input wire logic [63:0] drive_in, short_in, input wire logic hard_in,
  output logic [63:0] oc_out);
  // fault current flows while driven, or at any time while hard_in is set
  assign oc_out = short_in & (drive_in | {64{hard_in}});
endmodule // podp_panel_load
`default_nettype wire

// ==== test/podp_panel_io_monitor.sv ====
// port checker for the panel i/o protection logic
`timescale 1ns/100ps
`default_nettype none
module podp_monitor #(parameter N_OUT = 64, N_GRP = 8) (
  input wire logic clock_in, rst_in, rev_has_alarm_in, alarm_mask_jumper_in, system_alarm_out,
  input wire logic [N_OUT-1:0] output_cmd_in, overcurrent_detector_in, output_drive_out,
  input wire logic [N_GRP-1:0] overheat_detector_in, group_overheat_led_out);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  property p_cmd; output_drive_out[0] |-> $past(output_cmd_in[0]); endproperty
  a_cmd: assert property (p_cmd) else $error("drive without command");
  // pin to output takes three sync stages, the filter stage and the output flop
  property p_oc; overcurrent_detector_in[3][*6] |-> !output_drive_out[3]; endproperty
  a_oc: assert property (p_oc) else $error("output on in overcurrent");
  property p_oh; overheat_detector_in[1][*6] |-> output_drive_out[15:8] == 8'h00; endproperty
  a_oh: assert property (p_oh) else $error("group on in overheat");
  property p_led; (rev_has_alarm_in && overheat_detector_in[1])[*6]
    |-> group_overheat_led_out[1]; endproperty
  a_led: assert property (p_led) else $error("indicator dark");
  property p_held; !$fell(group_overheat_led_out[1]); endproperty
  a_held: assert property (p_held) else $error("indicator dropped");
  property p_rev; !rev_has_alarm_in |-> group_overheat_led_out == 0 && !system_alarm_out;
  endproperty
  a_rev: assert property (p_rev) else $error("status on old board");
  property p_msk; alarm_mask_jumper_in[*6] |-> !$rose(system_alarm_out); endproperty
  a_msk: assert property (p_msk) else $error("masked alarm raised");
  property p_alm; (|group_overheat_led_out && !alarm_mask_jumper_in)[*6] |-> system_alarm_out;
  endproperty
  a_alm: assert property (p_alm) else $error("alarm missing");
  c_trip: cover property (group_overheat_led_out[1] && system_alarm_out);
  c_mask: cover property (group_overheat_led_out[1] && alarm_mask_jumper_in);
  c_cyc: cover property ($fell(output_drive_out[3]));
endmodule // podp_monitor
bind podp_panel_io podp_monitor #(.N_OUT(N_OUT), .N_GRP(N_GRP)) u_mon (.*);
`default_nettype wire

// ==== test/podp_panel_io_test.sv ====
// self-checking bench for the panel i/o protection logic
`timescale 1ns/100ps
`default_nettype none
module podp_panel_io_test;
  logic clock_in = 0, rst_in = 1, rev_has_alarm_in = 1, alarm_mask_jumper_in = 0, hd = 1;
  logic [95:0] contact_closed_in = 0, input_bits_out;
  logic [63:0] output_cmd_in = 0, sh = 64'h8, overcurrent_detector_in, output_drive_out;
  logic [7:0] overheat_detector_in = 0, group_overheat_led_out;
  logic system_alarm_out;
  int errors = 0, samples_checked = 0, cyc = 0, n;
  podp_panel_io dut (.*);
  podp_panel_load load (.drive_in(output_drive_out), .short_in(sh), .hard_in(hd),
    .oc_out(overcurrent_detector_in));
  initial forever #10 clock_in = ~clock_in;
  task automatic chk(input logic [95:0] seen, exp);
    samples_checked++;
    if (seen !== exp) errors++;
    if (seen !== exp) $display("MISMATCH %0t %h %h", $time, seen, exp);
  endtask
  task automatic complete_run;
    if (cyc >= 999) errors++;
    $display("errors %0d compares %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 999) complete_run;
  end
  initial begin
    n = $urandom(32'hc6c1_0480);
    for (int r = 0; r < 3; r++) begin
      {rst_in, hd} = 2'h3;
      {rev_has_alarm_in, alarm_mask_jumper_in} = (r == 2) ? 2'h0 : {1'h1, r[0]};
      rst_in <= #80 1'h0;
      contact_closed_in = {$urandom, $urandom, $urandom};
      output_cmd_in = {$urandom, $urandom} | 64'hff08;
      repeat (10) @(negedge clock_in);
      chk(input_bits_out, contact_closed_in);
      chk(output_drive_out, output_cmd_in & ~sh);
      {hd, n} = 33'h0;
      repeat (40) @(negedge clock_in) n += output_drive_out[3];
      chk(n > 0 && n < 40, 1'h1);
      overheat_detector_in = 8'h02;
      overheat_detector_in <= #120 8'h00;
      repeat (11) @(negedge clock_in);
      chk({group_overheat_led_out, system_alarm_out, output_drive_out[15:8]}, {rev_has_alarm_in
        ? 8'h02 : 8'h00, rev_has_alarm_in & ~alarm_mask_jumper_in, 8'h00});
      output_cmd_in[8] = 1'h0;
      @(negedge clock_in) output_cmd_in[8] = 1'h1;
      repeat (2) @(negedge clock_in);
      chk(output_drive_out[15:8], 8'h01);
    end
    complete_run;
  end
endmodule // podp_panel_io_test
`default_nettype wire
